/* File: verification/epc_host_model.sv */
// ----------------------------------------------------------------
// Host model: register accesses and transaction ends
// ----------------------------------------------------------------
module epc_host_model (
   // Clock
   input  wire logic             clk,
   // Requests towards the block
   output epc_pkg::epc_reg_req_t reg_req
);
   timeunit 1ns;
   timeprecision 1ps;

   // Bus idle at time zero
   initial reg_req = '0;

   // One access, launched after an edge and held through the taking edge
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clk);
      #1;
      reg_req.wr    = wr;
      reg_req.rd    = ~wr;
      reg_req.addr  = addr;
      reg_req.wdata = data;
      @(posedge clk);
      #1;
      reg_req.wr    = 1'b0;
      reg_req.rd    = 1'b0;
      // Released lines show the inverse, never the stale value
      reg_req.addr  = ~addr;
      reg_req.wdata = ~data;
   endtask

   // End of the current transaction
   task automatic stop();
      @(posedge clk);
      #1;
      reg_req.txn_end = 1'b1;
      @(posedge clk);
      #1;
      reg_req.txn_end = 1'b0;
   endtask

   // Unlock and start, nothing in between
   task automatic unlock_and_start(input logic [7:0] code, input logic [7:0] ctl);
      access(1'b1, epc_pkg::UNLOCK_ADDR, code);
      stop();
      access(1'b1, epc_pkg::MEM_CTRL_ADDR, ctl);
      stop();
   endtask
endmodule

/* File: verification/tb_eeprom_program_control.sv */
module tb_eeprom_program_control;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int          PROG = 20;         // Shortened program time
   logic                   clk;
   logic                   reset;
   epc_pkg::epc_reg_req_t  reg_req;
   logic [7:0]             reg_rdata_q;
   logic [7:0]             copy_page;
   logic                   copy_done;
   logic                   copy_req_q;
   logic [7:0]             copy_page_q;
   logic                   prog_req_q;
   logic                   prog_auto_crc_q;
   logic                   array_block_q;
   epc_pkg::epc_readback_t readback;
   logic                   count_load;
   logic [7:0]             count_value;
   logic [7:0]             cycle_count_q;
   int                     error_cnt = 0;     // Mismatches
   int                     compares = 0;      // Comparisons
   int                     busy_cnt = 0;      // Running busy length
   int                     busy_len = 0;      // Last busy length
   int                     req_cnt = 0;       // Program request pulses seen
   logic [7:0]             seen_page = 8'h00; // Page seen at copy start
   logic [7:0]             exp_cnt;
   logic [7:0]             crc;
   logic [7:0]             page;
   logic                   auto;

   // Design and host
   epc_control #(.PROG_CYCLES(PROG)) epc_control_inst (
      .clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata_q(reg_rdata_q),
      .copy_page(copy_page), .copy_req_q(copy_req_q), .copy_page_q(copy_page_q),
      .copy_done(copy_done), .prog_req_q(prog_req_q), .prog_auto_crc_q(prog_auto_crc_q),
      .array_block_q(array_block_q), .readback(readback), .count_load(count_load),
      .count_value(count_value), .cycle_count_q(cycle_count_q));
   epc_host_model epc_host_model_inst (.clk(clk), .reg_req(reg_req));

   // ----------------------------------------------------------------
   // Clock, watchdog, monitors
   // ----------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Cuts a hang short
   initial
   begin
      #(5000 * 40);
      error_cnt++;
      finish_test();
   end

   // Busy length and captured copy page
   always @(posedge clk)
   begin
      busy_cnt <= array_block_q ? busy_cnt + 1 : 0;
      if (array_block_q)
         busy_len <= busy_cnt + 1;
      if (copy_req_q)
         seen_page <= copy_page_q;
      if (prog_req_q)
         req_cnt <= req_cnt + 1;
   end

   // ----------------------------------------------------------------
   // Tasks and functions
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Compares %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Read in its own transaction and compare
   task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
      epc_host_model_inst.access(1'b0, addr, 8'h00);
      epc_host_model_inst.stop();
      check(reg_rdata_q, exp);
   endtask

   // One-cycle readback event
   task automatic rb(input logic st, input logic v, input logic f, input logic [7:0] d);
      @(posedge clk);
      #1;
      readback = {st, v, d, f};
      @(posedge clk);
      #1;
      readback = {2'b00, ~d, 1'b0};
   endtask

   // Wait out a program cycle
   task automatic idle();
      int n;
      n = 0;
      while (array_block_q !== 1'b0 && n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check({7'h00, array_block_q}, 8'h00);
   endtask

   // Expected live CRC, MSB first
   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
      c = c ^ d;
      for (int i = 0; i < 8; i++)
         c = c[7] ? ((c << 1) ^ epc_pkg::CRC_POLY) : (c << 1);
      return c;
   endfunction

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      reset = 1'b1;
      copy_page = 8'h00;
      copy_done = 1'b0;
      readback = '0;
      count_load = 1'b0;
      count_value = 8'h00;
      void'($urandom(32'h5b761445));
      repeat (8) @(posedge clk);
      #1;
      reset = 1'b0;
      rchk(epc_pkg::MEM_CTRL_ADDR, 8'h10);
      rchk(epc_pkg::LIVE_CRC_ADDR, 8'h00);
      rchk(8'h55, 8'h00);
      $display("Test reset values done");
      // Start with no unlock, a wrong code, and an unlock cancelled by a read
      epc_host_model_inst.access(1'b1, epc_pkg::MEM_CTRL_ADDR, 8'h11);
      epc_host_model_inst.stop();
      epc_host_model_inst.unlock_and_start(~epc_pkg::UNLOCK_CODE, 8'h11);
      epc_host_model_inst.access(1'b1, epc_pkg::UNLOCK_ADDR, epc_pkg::UNLOCK_CODE);
      epc_host_model_inst.stop();
      rchk(epc_pkg::LIVE_CRC_ADDR, 8'h00);
      epc_host_model_inst.access(1'b1, epc_pkg::MEM_CTRL_ADDR, 8'h11);
      epc_host_model_inst.stop();
      check({7'h00, array_block_q}, 8'h00);
      check(cycle_count_q, 8'h00);
      check(req_cnt[7:0], 8'h00);
      $display("Test refused starts done");
      // Accepted start, second start while busy is ignored
      epc_host_model_inst.unlock_and_start(epc_pkg::UNLOCK_CODE, 8'h11);
      check({7'h00, prog_auto_crc_q}, 8'h01);
      rchk(epc_pkg::MEM_CTRL_ADDR, 8'h14);
      epc_host_model_inst.unlock_and_start(epc_pkg::UNLOCK_CODE, 8'h11);
      idle();
      check(busy_len[7:0], 8'(PROG));
      check(cycle_count_q, 8'h01);
      check(req_cnt[7:0], 8'h01);
      $display("Test program cycle done");
      // Counter saturation with random auto-CRC setting
      @(posedge clk);
      #1;
      count_load = 1'b1;
      count_value = 8'hfd;
      @(posedge clk);
      #1;
      count_load = 1'b0;
      exp_cnt = 8'hfd;
      for (int i = 0; i < 3; i++)
      begin
         auto = 1'($urandom);
         epc_host_model_inst.access(1'b1, epc_pkg::MEM_CTRL_ADDR, {3'h0, auto, 4'h0});
         epc_host_model_inst.stop();
         epc_host_model_inst.unlock_and_start(epc_pkg::UNLOCK_CODE, {3'h0, auto, 4'h1});
         check({7'h00, prog_auto_crc_q}, {7'h00, auto});
         idle();
         exp_cnt = (exp_cnt == 8'hff) ? exp_cnt : exp_cnt + 8'h01;
         check(cycle_count_q, exp_cnt);
      end
      check(req_cnt[7:0], 8'h04);
      $display("Test counter saturation done");
      // Register-to-SRAM copy to a random page
      page = 8'($urandom) | 8'h01;
      copy_page = page;
      epc_host_model_inst.access(1'b1, epc_pkg::MEM_CTRL_ADDR, {3'h2, auto, 4'h0});
      copy_page = ~page;
      epc_host_model_inst.stop();
      check(seen_page, page);
      rchk(epc_pkg::MEM_CTRL_ADDR, {3'h2, auto, 4'h0});
      @(posedge clk);
      #1;
      copy_done = 1'b1;
      @(posedge clk);
      #1;
      copy_done = 1'b0;
      rchk(epc_pkg::MEM_CTRL_ADDR, {3'h0, auto, 4'h0});
      $display("Test copy done");
      // Readback: live CRC, error flag, read-only bits
      rb(1'b1, 1'b0, 1'b0, 8'h00);
      crc = 8'h00;
      repeat (4)
      begin
         page = 8'($urandom);
         rb(1'b0, 1'b1, 1'b0, page);
         crc = crc8(crc, page);
      end
      rchk(epc_pkg::LIVE_CRC_ADDR, crc);
      rb(1'b0, 1'b0, 1'b1, 8'h00);
      epc_host_model_inst.access(1'b1, epc_pkg::MEM_CTRL_ADDR, 8'haa);
      epc_host_model_inst.stop();
      rchk(epc_pkg::MEM_CTRL_ADDR, 8'h20);
      rb(1'b1, 1'b0, 1'b0, 8'h00);
      rchk(epc_pkg::MEM_CTRL_ADDR, 8'h00);
      rchk(epc_pkg::LIVE_CRC_ADDR, 8'h00);
      $display("Test readback done");
      finish_test();
   end
endmodule

/* File: verilog/epc_control.sv */
// Notes on behaviour
// - Writing copy bit starts register-to-SRAM copy
// - Copy bit clears itself when copy done
// - Copy page comes from page-select register
// - Readback CRC failure sets error flag
// - Auto-CRC bit, reset one, adds CRC
// - Busy flag high exactly during program cycle
// - Array access blocked while busy
// - Program-start bit requests erase/program cycle
// - Program needs unlock write in prior transaction
// - Program-start bit clears itself after acceptance
// - Program cycle lasts about 230 ms
// - Live CRC byte, read-only, resets zero
// - Bit 7 reserved; bit 1 self-clears
// - Cycle counter increments, saturates at 255
module epc_control #(
   parameter int PROG_CYCLES = epc_pkg::PROG_CYCLES
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   reset,
   // Register access from the I2C slave
   input  wire epc_pkg::epc_reg_req_t  reg_req,
   output logic [7:0]                  reg_rdata_q,
   // Page-select register value
   input  wire logic [7:0]             copy_page,
   // Register-to-SRAM copy engine
   output logic                        copy_req_q,
   output logic [7:0]                  copy_page_q,
   input  wire logic                   copy_done,
   // EEPROM program engine
   output logic                        prog_req_q,
   output logic                        prog_auto_crc_q,
   output logic                        array_block_q,
   // Configuration readback
   input  wire epc_pkg::epc_readback_t readback,
   input  wire logic                   count_load,
   input  wire logic [7:0]             count_value,
   output logic [7:0]                  cycle_count_q
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      EPC_IDLE = 2'b01,
      EPC_PROG = 2'b10
   } epc_state_t;

   epc_state_t  state_q;            // Program sequencer
   logic [31:0] timer_q;            // Program-cycle timer
   logic        copy_bit_q;         // reg_to_sram_copy
   logic        crc_err_q;          // crc_error_flag
   logic        auto_crc_q;         // auto_crc_enable
   logic        rsvd1_q;            // Reserved self-clearing bit
   logic        prog_bit_q;         // program_start
   logic        unlock_cur_q;       // Unlock written in current transaction
   logic        unlock_prev_q;      // Unlock written in previous transaction
   logic [7:0]  live_crc_q;         // live_crc_value
   logic        ctrl_wr;            // Write to memory_control
   logic        prog_accept;        // Accepted program request
   logic        prog_end;           // Last cycle of program cycle

   // Live CRC update by one byte, MSB first
   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
      begin
         c = c[7] ? ((c << 1) ^ epc_pkg::CRC_POLY) : (c << 1);
      end
      return c;
   endfunction

   assign ctrl_wr     = reg_req.wr && (reg_req.addr == epc_pkg::MEM_CTRL_ADDR);
   assign prog_accept = ctrl_wr && reg_req.wdata[epc_pkg::BIT_PROG]
                        && unlock_prev_q && (state_q == EPC_IDLE);
   assign prog_end    = (state_q == EPC_PROG) && (timer_q == 32'(PROG_CYCLES - 1));

   // ----------------------------------------------------------------
   // Unlock tracking
   // ----------------------------------------------------------------
   // Remember whether the transaction just ended wrote the unlock code
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         unlock_cur_q  <= 1'b0;
         unlock_prev_q <= 1'b0;
      end
      else if (reg_req.txn_end)
      begin
         unlock_prev_q <= unlock_cur_q
                          || (reg_req.wr && reg_req.addr == epc_pkg::UNLOCK_ADDR
                              && reg_req.wdata == epc_pkg::UNLOCK_CODE);
         unlock_cur_q  <= 1'b0;
      end
      else if (reg_req.wr && reg_req.addr == epc_pkg::UNLOCK_ADDR)
      begin
         unlock_cur_q  <= (reg_req.wdata == epc_pkg::UNLOCK_CODE);
      end
   end

   // ----------------------------------------------------------------
   // Program sequencer
   // ----------------------------------------------------------------
   // Idle until an accepted request, then time the cycle
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_q <= EPC_IDLE;
         timer_q <= 32'h0000_0000;
      end
      else
      begin
         unique case (state_q)
            EPC_IDLE:
            begin
               timer_q <= 32'h0000_0000;
               if (prog_accept)
                  state_q <= EPC_PROG;
            end
            EPC_PROG:
            begin
               timer_q <= timer_q + 32'h0000_0001;
               if (prog_end)
                  state_q <= EPC_IDLE;
            end
            // Illegal codes fall back to idle
            default:
               state_q <= EPC_IDLE;
         endcase
      end
   end

   // Request pulse, CRC mode and array block toward the engine
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         prog_req_q      <= 1'b0;
         prog_auto_crc_q <= epc_pkg::AUTO_CRC_RST;
         array_block_q   <= 1'b0;
      end
      else
      begin
         prog_req_q    <= prog_accept;
         array_block_q <= prog_accept || ((state_q == EPC_PROG) && !prog_end);
         if (prog_accept)
            prog_auto_crc_q <= auto_crc_q;
      end
   end

   // Saturating program-cycle counter
   always_ff @(posedge clk)
   begin
      if (reset)
         cycle_count_q <= epc_pkg::COUNT_RST;
      else if (count_load)
         cycle_count_q <= count_value;
      else if (prog_end && cycle_count_q != epc_pkg::COUNT_MAX)
         cycle_count_q <= cycle_count_q + 8'h01;
   end

   // ----------------------------------------------------------------
   // memory_control bits
   // ----------------------------------------------------------------
   // Copy request and its self-clear on completion
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         copy_bit_q  <= 1'b0;
         copy_req_q  <= 1'b0;
         copy_page_q <= 8'h00;
      end
      else
      begin
         copy_req_q <= 1'b0;
         if (ctrl_wr && reg_req.wdata[epc_pkg::BIT_COPY] && !copy_bit_q)
         begin
            copy_bit_q  <= 1'b1;
            copy_req_q  <= 1'b1;
            copy_page_q <= copy_page;
         end
         else if (copy_done)
            copy_bit_q <= 1'b0;
      end
   end

   // Writable and self-clearing control bits
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         auto_crc_q <= epc_pkg::AUTO_CRC_RST;
         rsvd1_q    <= 1'b0;
         prog_bit_q <= 1'b0;
      end
      else
      begin
         rsvd1_q    <= ctrl_wr && reg_req.wdata[epc_pkg::BIT_RSVD1];
         prog_bit_q <= prog_accept;
         if (ctrl_wr)
            auto_crc_q <= reg_req.wdata[epc_pkg::BIT_AUTO_CRC];
      end
   end

   // Readback CRC: live byte and sticky error, set wins
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         live_crc_q <= epc_pkg::LIVE_CRC_RST;
         crc_err_q  <= 1'b0;
      end
      else
      begin
         if (readback.start)
         begin
            live_crc_q <= epc_pkg::LIVE_CRC_RST;
            crc_err_q  <= 1'b0;
         end
         if (readback.valid)
            live_crc_q <= crc8_step(readback.start ? epc_pkg::LIVE_CRC_RST : live_crc_q,
                                    readback.data);
         if (readback.fail)
            crc_err_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   // Read data registered on the read strobe; unmapped reads give zero
   always_ff @(posedge clk)
   begin
      if (reset)
         reg_rdata_q <= 8'h00;
      else if (reg_req.rd)
      begin
         unique case (reg_req.addr)
            epc_pkg::MEM_CTRL_ADDR:
               reg_rdata_q <= {1'b0, copy_bit_q, crc_err_q, auto_crc_q,
                               1'b0, array_block_q, rsvd1_q, prog_bit_q};
            epc_pkg::LIVE_CRC_ADDR:
               reg_rdata_q <= live_crc_q;
            default:
               reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence accept_s;
      prog_accept;
   endsequence

   sequence busy_run_s;
      array_block_q [*8];
   endsequence

   copy_start_a: assert property (ctrl_wr && reg_req.wdata[6] && !copy_bit_q |=> copy_req_q && copy_bit_q
                                  && copy_page_q == $past(copy_page))
      else $error("copy not started");
   copy_clear_a: assert property (copy_bit_q && copy_done && !ctrl_wr |=> !copy_bit_q)
      else $error("copy bit not cleared");
   crc_flag_a: assert property (readback.fail |=> crc_err_q)
      else $error("crc error not flagged");
   busy_hold_a: assert property (accept_s |=> busy_run_s)
      else $error("busy dropped early");
   busy_match_a: assert property (array_block_q == (state_q == EPC_PROG))
      else $error("block and sequencer disagree");
   prog_lock_a: assert property (ctrl_wr && reg_req.wdata[0] && !unlock_prev_q |=> !prog_req_q)
      else $error("program without unlock");
   prog_selfclr_a: assert property (prog_bit_q |=> !prog_bit_q)
      else $error("program bit stuck");
   busy_ignore_a: assert property (array_block_q && !prog_end |-> !prog_accept)
      else $error("start accepted while busy");
   count_sat_a: assert property (prog_end && !count_load && cycle_count_q == 8'hff |=>
                                 cycle_count_q == 8'hff)
      else $error("counter wrapped");
   cycle_len_a: assert property (prog_end |=> !array_block_q ##0 $past(timer_q) == 32'(PROG_CYCLES - 1))
      else $error("cycle length wrong");

endmodule

/* File: verilog/epc_pkg.sv */
package epc_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] MEM_CTRL_ADDR   = 8'h89;   // memory_control
   localparam logic [7:0] LIVE_CRC_ADDR   = 8'h8a;   // live_crc_value
   localparam logic [7:0] UNLOCK_ADDR     = 8'h8f;   // program_unlock (placement chosen)
   localparam logic [7:0] UNLOCK_CODE     = 8'hea;   // Unlock code (value arbitrary)

   // ----------------------------------------------------------------
   // memory_control field positions and reset values
   // ----------------------------------------------------------------
   localparam int         BIT_COPY        = 6;       // reg_to_sram_copy
   localparam int         BIT_CRC_ERR     = 5;       // crc_error_flag
   localparam int         BIT_AUTO_CRC    = 4;       // auto_crc_enable
   localparam int         BIT_LOAD        = 3;       // eeprom_to_sram_load
   localparam int         BIT_BUSY        = 2;       // program_busy
   localparam int         BIT_RSVD1       = 1;       // Reserved, self-clearing
   localparam int         BIT_PROG        = 0;       // program_start
   localparam logic       AUTO_CRC_RST    = 1'b1;
   localparam logic [7:0] LIVE_CRC_RST    = 8'h00;
   localparam logic [7:0] COUNT_RST       = 8'h00;
   localparam logic [7:0] COUNT_MAX       = 8'hff;
   localparam logic [7:0] CRC_POLY        = 8'h07;   // Live CRC polynomial (chosen)

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int         CLK_HZ          = 25000000;
   localparam int         PROG_TIME_MS    = 230;
   localparam int         PROG_CYCLES     = PROG_TIME_MS * (CLK_HZ / 1000);

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic       wr;      // One-cycle register write strobe
      logic       rd;      // One-cycle register read strobe
      logic       txn_end; // One-cycle pulse at end of each I2C transaction
      logic [7:0] addr;    // Register address
      logic [7:0] wdata;   // Write data
   } epc_reg_req_t;

   typedef struct packed
   {
      logic       start;   // Configuration readback begins
      logic       valid;   // One EEPROM byte read back
      logic [7:0] data;    // The byte
      logic       fail;    // Stored CRC did not match at end of readback
   } epc_readback_t;

endpackage
